// ---- scm_cfg.svh ----
// Offsets, field positions, reset values and timing counts for the system and mode control block
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SCM_SYSCTL_ADDR 12'h000
`define SCM_MODECTL_ADDR 12'h004

// ----------------------------------------
// System control fields
// ----------------------------------------
`define SCM_STBY_BIT 7
`define SCM_STS_HI 6
`define SCM_STS_LO 4
`define SCM_RSTSRC_BIT 3
`define SCM_NMIEDGE_BIT 2
`define SCM_HOSTEN_BIT 1
`define SCM_RAMEN_BIT 0
`define SCM_SYSCTL_RESET 8'h09

// ----------------------------------------
// Mode control constant image (bit 7, 6, 5, 2 one; 4, 3 zero)
// ----------------------------------------
`define SCM_MODECTL_FIXED 8'hE4

// ----------------------------------------
// Settling counts in states
// ----------------------------------------
`define SCM_SETTLE_0 32'd8192
`define SCM_SETTLE_1 32'd16384
`define SCM_SETTLE_2 32'd32768
`define SCM_SETTLE_3 32'd65536
`define SCM_SETTLE_4 32'd131072
`define SCM_SETTLE_5 32'd1024

`endif

// ---- scm_pkg.sv ----
// Types shared by the system and mode control block
`default_nettype none
package scm_pkg;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_STANDBY,
        PWR_SETTLE
    } scm_pwr_type;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_EXP_NOROM,
        MODE_EXP_ROM,
        MODE_SINGLE
    } scm_opmode_type;
endpackage
`default_nettype wire

// ---- scm_settle_if.sv ----
// Link between the control registers and the settling timer
`timescale 1ns/10ps
`default_nettype none
interface scm_settle_if;
    logic start;
    logic [2:0] code;
    logic flashBuild;
    logic busy;
    logic done;
    modport ctrl (output start, output code, output flashBuild, input busy, input done);
    modport timer (input start, input code, input flashBuild, output busy, output done);
endinterface
`default_nettype wire

// ---- scm_settle_timer.sv ----
// Oscillator settling timer used on wake from software standby
`timescale 1ns/10ps
`default_nettype none
`include "scm_cfg.svh"
module scm_settle_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    scm_settle_if.timer st
);
    logic [17:0] cnt_r;
    logic [17:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic done_r;
    logic done_nxt;

    // Unused codes fall back to the longest safe time
    function automatic logic [17:0] settleCount(input logic [2:0] c, input logic fl);
        case (c)
            3'h0: settleCount = 18'(`SCM_SETTLE_0);
            3'h1: settleCount = 18'(`SCM_SETTLE_1);
            3'h2: settleCount = 18'(`SCM_SETTLE_2);
            3'h3: settleCount = 18'(`SCM_SETTLE_3);
            3'h4: settleCount = 18'(`SCM_SETTLE_4);
            3'h5: settleCount = fl ? 18'(`SCM_SETTLE_5) : 18'(`SCM_SETTLE_4);
            default: settleCount = 18'(`SCM_SETTLE_4);
        endcase
    endfunction

    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (st.start) begin
            cnt_nxt = settleCount(st.code, st.flashBuild) - 18'h00001; // RQ4 RQ5
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (cnt_r == 18'h00000) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 18'h00001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 18'h00000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign st.busy = busy_r;
    assign st.done = done_r;

    chk_short_code: assert property (@(posedge clk) disable iff (rst) // RQ5
        (ce && st.start && st.code == 3'h5 && st.flashBuild) |=> (cnt_r == 18'h003FF))
        else $error("flash code 101 did not load 1024 states");
    chk_base_code: assert property (@(posedge clk) disable iff (rst) // RQ4
        (ce && st.start && st.code == 3'h0) |=> (cnt_r == 18'h01FFF))
        else $error("code 000 did not load 8192 states");
endmodule
`default_nettype wire

// ---- scm_sysmode_ctrl.sv ----
// System control and mode control registers with APB access and standby sequencing
// What this block and the software driving it must do
// RQ1: Standby select 0 makes sleep enter sleep; 1 enters software standby; resets 0.
// RQ2: Standby select stays 1 after interrupt wake; clears only by software writing 0.
// RQ3: After interrupt wake from standby, CPU and peripherals halt for the settling time.
// RQ4: Mask ROM codes 000..100 give 8192..131072 states; remaining code unused.
// RQ5: Flash codes 000..100 as mask ROM; 101 gives 1024 states; 11x unused.
// RQ6: Software picks a settling code giving at least 8 ms at its clock.
// RQ7: With slow timer clocks, use code 101 only just before sleep, then restore.
// RQ8: Reset source flag is read-only; external reset sets it, watchdog reset clears it.
// RQ9: Edge select 0 requests NMI on falling edge; 1 on rising; resets 0.
// RQ10: Host port enable 1 activates host slave interface; 0, the reset value, disables.
// RQ11: RAM enable 1 enables RAM; reset sets 1; standby leaves it unchanged.
// RQ12: Without single-supply flash, mode register top bit ignores writes, reads 1.
// RQ13: Mode bits 6,5,2 read 1 and bits 4,3 read 0; writes ignored.
// RQ14: Mode bits 1,0 copy the mode pins, latched whenever the register is read.
// RQ15: Mode pins 01, 10, 11 select expanded no-ROM, expanded ROM, single-chip modes.
// RQ16: In expanded modes, RAM disabled routes on-chip RAM range off-chip.
// RQ17: Writes to read-only reset source and mode pin bits are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "scm_cfg.svh"
module scm_sysmode_ctrl #(
    parameter bit FLASH_BUILD = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic watchdogReset,
    input wire logic sleepExec,
    input wire logic extIrqWake,
    input wire logic nmiPin,
    input wire logic mode_pin_hi,
    input wire logic mode_pin_lo,
    output logic cpuHalt,
    output logic periphHalt,
    output logic periphInit,
    output logic nmiRequest,
    output logic host_port_enable,
    output logic onchip_ram_enable,
    output logic ramRouteOffchip,
    output logic [1:0] opMode
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] sysCtl_r;
    logic [7:0] sysCtl_nxt;
    logic [1:0] modeImg_r;
    logic [1:0] modeImg_nxt;
    logic rstSeen_r;
    logic rstSeen_nxt;
    scm_pkg::scm_pwr_type pwr_r;
    scm_pkg::scm_pwr_type pwr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic cpuHalt_r;
    logic cpuHalt_nxt;
    logic periphHalt_r;
    logic periphHalt_nxt;
    logic periphInit_r;
    logic periphInit_nxt;
    logic nmiReq_r;
    logic nmiReq_nxt;
    logic ramRoute_r;
    logic ramRoute_nxt;
    logic [1:0] opMode_r;
    logic [1:0] opMode_nxt;
    logic nmiMeta_r;
    logic nmiSync_r;
    logic nmiPrev_r;
    logic [1:0] modeMeta_r;
    logic [1:0] modeSync_r;
    logic wdMeta_r;
    logic wdSync_r;
    logic setupWin;
    logic accessWr;
    logic accessRd;
    logic hitSys;
    logic hitMode;

    scm_settle_if st();

    scm_settle_timer u_timer (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .st(st)
    );

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            nmiMeta_r <= 1'b1;
            nmiSync_r <= 1'b1;
            nmiPrev_r <= 1'b1;
            modeMeta_r <= 2'h3;
            modeSync_r <= 2'h3;
        end else if (ce) begin
            nmiMeta_r <= nmiPin;
            nmiSync_r <= nmiMeta_r;
            nmiPrev_r <= nmiSync_r;
            modeMeta_r <= {mode_pin_hi, mode_pin_lo};
            modeSync_r <= modeMeta_r;
        end
    end

    // Reset cause keeps sampling through reset, else the flag could never see a watchdog reset
    always_ff @(posedge clk) begin
        if (ce) begin
            wdMeta_r <= watchdogReset;
            wdSync_r <= wdMeta_r;
        end
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // One wait state: pready rises in the second access cycle
    assign setupWin = psel && penable && !pready_r;
    assign accessWr = setupWin && pwrite;
    assign accessRd = setupWin && !pwrite;
    assign hitSys = (paddr == `SCM_SYSCTL_ADDR);
    assign hitMode = (paddr == `SCM_MODECTL_ADDR);

    always_comb begin
        sysCtl_nxt = sysCtl_r;
        modeImg_nxt = modeImg_r;
        rstSeen_nxt = 1'b1;
        prdata_nxt = prdata_r;
        pready_nxt = setupWin;
        pslverr_nxt = 1'b0;
        if (!rstSeen_r) begin
            // Reset source caught after release; watchdog clears, external sets
            sysCtl_nxt[`SCM_RSTSRC_BIT] = !wdSync_r; // RQ8
        end
        if (accessWr && hitSys) begin
            sysCtl_nxt[7:4] = pwdata[7:4]; // RQ1 RQ2
            sysCtl_nxt[2:0] = pwdata[2:0]; // RQ9 RQ10 RQ11 RQ17
        end
        if (accessRd && hitMode) begin
            modeImg_nxt = modeSync_r; // RQ14
        end
        if (setupWin) begin
            pslverr_nxt = !(hitSys || hitMode);
            if (!pwrite) begin
                if (hitSys) begin
                    prdata_nxt = {24'h000000, sysCtl_r};
                end else if (hitMode) begin
                    prdata_nxt = {24'h000000, `SCM_MODECTL_FIXED | {6'h00, modeSync_r}}; // RQ12 RQ13 RQ14
                end else begin
                    prdata_nxt = 32'h00000000;
                end
            end
        end
    end

    // ----------------------------------------
    // Power sequencing
    // ----------------------------------------
    assign st.code = sysCtl_r[`SCM_STS_HI:`SCM_STS_LO];
    assign st.flashBuild = FLASH_BUILD;
    assign st.start = (pwr_r == scm_pkg::PWR_STANDBY) && extIrqWake; // RQ3

    always_comb begin
        pwr_nxt = pwr_r;
        cpuHalt_nxt = 1'b0;
        periphHalt_nxt = 1'b0;
        periphInit_nxt = 1'b0;
        case (pwr_r)
            scm_pkg::PWR_RUN: begin
                if (sleepExec) begin
                    pwr_nxt = sysCtl_r[`SCM_STBY_BIT] ? scm_pkg::PWR_STANDBY : scm_pkg::PWR_SLEEP; // RQ1
                end
            end
            scm_pkg::PWR_SLEEP: begin
                if (extIrqWake) begin
                    pwr_nxt = scm_pkg::PWR_RUN;
                end
            end
            scm_pkg::PWR_STANDBY: begin
                if (extIrqWake) begin
                    pwr_nxt = scm_pkg::PWR_SETTLE;
                end
            end
            scm_pkg::PWR_SETTLE: begin
                if (st.done) begin
                    pwr_nxt = scm_pkg::PWR_RUN;
                end
            end
            default: pwr_nxt = scm_pkg::PWR_RUN;
        endcase
        // Onchip RAM enable is not touched by standby entry
        cpuHalt_nxt = (pwr_nxt != scm_pkg::PWR_RUN); // RQ3
        periphHalt_nxt = (pwr_nxt == scm_pkg::PWR_STANDBY) || (pwr_nxt == scm_pkg::PWR_SETTLE); // RQ3 RQ11
        periphInit_nxt = (pwr_nxt == scm_pkg::PWR_STANDBY);
    end

    // ----------------------------------------
    // Derived outputs
    // ----------------------------------------
    always_comb begin
        nmiReq_nxt = sysCtl_r[`SCM_NMIEDGE_BIT] ? (nmiSync_r && !nmiPrev_r)
                                                : (!nmiSync_r && nmiPrev_r); // RQ9
        opMode_nxt = modeSync_r; // RQ15
        ramRoute_nxt = !sysCtl_r[`SCM_RAMEN_BIT] &&
                       (modeSync_r == 2'h1 || modeSync_r == 2'h2); // RQ16
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sysCtl_r <= `SCM_SYSCTL_RESET;
            modeImg_r <= 2'h3;
            rstSeen_r <= 1'b0;
            pwr_r <= scm_pkg::PWR_RUN;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            cpuHalt_r <= 1'b0;
            periphHalt_r <= 1'b0;
            periphInit_r <= 1'b0;
            nmiReq_r <= 1'b0;
            ramRoute_r <= 1'b0;
            opMode_r <= 2'h3;
        end else if (ce) begin
            sysCtl_r <= sysCtl_nxt;
            modeImg_r <= modeImg_nxt;
            rstSeen_r <= rstSeen_nxt;
            pwr_r <= pwr_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            cpuHalt_r <= cpuHalt_nxt;
            periphHalt_r <= periphHalt_nxt;
            periphInit_r <= periphInit_nxt;
            nmiReq_r <= nmiReq_nxt;
            ramRoute_r <= ramRoute_nxt;
            opMode_r <= opMode_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cpuHalt = cpuHalt_r;
    assign periphHalt = periphHalt_r;
    assign periphInit = periphInit_r;
    assign nmiRequest = nmiReq_r;
    assign host_port_enable = sysCtl_r[`SCM_HOSTEN_BIT]; // RQ10
    assign onchip_ram_enable = sysCtl_r[`SCM_RAMEN_BIT]; // RQ11
    assign ramRouteOffchip = ramRoute_r;
    assign opMode = opMode_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_sleep_select: assert property (@(posedge clk) disable iff (rst) // RQ1
        (ce && pwr_r == scm_pkg::PWR_RUN && sleepExec) |=>
        (pwr_r == (sysCtl_r[`SCM_STBY_BIT] ? scm_pkg::PWR_STANDBY : scm_pkg::PWR_SLEEP)))
        else $error("sleep entered wrong power mode");
    chk_standby_sticky: assert property (@(posedge clk) disable iff (rst) // RQ2
        (ce && pwr_r == scm_pkg::PWR_SETTLE && st.done) |=> sysCtl_r[`SCM_STBY_BIT] == $past(sysCtl_r[`SCM_STBY_BIT]))
        else $error("standby select changed on wake");
    chk_settle_halt: assert property (@(posedge clk) disable iff (rst) // RQ3
        (pwr_r == scm_pkg::PWR_SETTLE) |-> (cpuHalt && periphHalt))
        else $error("resumed before settling ended");
    chk_rstsrc_ro: assert property (@(posedge clk) disable iff (rst) // RQ17
        (ce && rstSeen_r && accessWr && hitSys) |=> $stable(sysCtl_r[`SCM_RSTSRC_BIT]))
        else $error("reset source flag was written");
    chk_nmi_falling: assert property (@(posedge clk) disable iff (rst) // RQ9
        (ce && !sysCtl_r[`SCM_NMIEDGE_BIT] && nmiPrev_r && !nmiSync_r) |=> nmiRequest)
        else $error("falling nmi edge missed");
    chk_mode_fixed: assert property (@(posedge clk) disable iff (rst) // RQ13
        (ce && accessRd && hitMode) |=> (prdata[7:2] == 6'h39))
        else $error("mode fixed bits wrong");
    chk_ram_route: assert property (@(posedge clk) disable iff (rst) // RQ16
        (ce && modeSync_r == 2'h3) |=> !ramRouteOffchip)
        else $error("single-chip mode routed RAM off-chip");
    chk_ram_reset: assert property (@(posedge clk) // RQ11
        rst |=> onchip_ram_enable)
        else $error("RAM enable not set by reset");
    chk_settle_busy: assert property (@(posedge clk) disable iff (rst) // RQ3
        (pwr_r == scm_pkg::PWR_SETTLE) |-> (st.busy || st.done))
        else $error("settling timer idle while halted");
    chk_nmi_rising: assert property (@(posedge clk) disable iff (rst) // RQ9
        (ce && sysCtl_r[`SCM_NMIEDGE_BIT] && !nmiPrev_r && nmiSync_r) |=> nmiRequest)
        else $error("rising nmi edge missed");
    chk_stby_hold: assert property (@(posedge clk) disable iff (rst) // RQ2
        (ce && !(accessWr && hitSys)) |=> $stable(sysCtl_r[`SCM_STBY_BIT]))
        else $error("standby select changed without a write");
    chk_sleep_periph: assert property (@(posedge clk) disable iff (rst) // RQ1
        (pwr_r == scm_pkg::PWR_SLEEP) |-> !periphHalt)
        else $error("peripherals halted in sleep");
    chk_mode_latch: assert property (@(posedge clk) disable iff (rst) // RQ14
        (ce && accessRd && hitMode) |=> (modeImg_r == prdata[1:0]))
        else $error("mode pin image not latched on read");
endmodule
`default_nettype wire

// ---- test_scm_sysmode_ctrl.sv ----
// Self-checking testbench for the system and mode control registers
`timescale 1ns/10ps
`default_nettype none
`include "scm_cfg.svh"
module test_scm_sysmode_ctrl;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, cpuHalt, periphHalt, periphInit, nmiRequest;
    logic host_port_enable, onchip_ram_enable, ramRouteOffchip;
    logic [1:0] opMode;
    logic watchdogReset = 1'b0;
    logic sleepExec = 1'b0;
    logic extIrqWake = 1'b0;
    logic nmiPin = 1'b1;
    logic mode_pin_hi = 1'b1;
    logic mode_pin_lo = 1'b1;
    int failCount = 0;
    int nTests = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    // Flash build so that the short settling code is available
    scm_sysmode_ctrl #(.FLASH_BUILD(1'b1)) dut (
        .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watchdogReset(watchdogReset), .sleepExec(sleepExec), .extIrqWake(extIrqWake),
        .nmiPin(nmiPin), .mode_pin_hi(mode_pin_hi), .mode_pin_lo(mode_pin_lo),
        .cpuHalt(cpuHalt), .periphHalt(periphHalt), .periphInit(periphInit),
        .nmiRequest(nmiRequest), .host_port_enable(host_port_enable),
        .onchip_ram_enable(onchip_ram_enable), .ramRouteOffchip(ramRouteOffchip), .opMode(opMode));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            wrapUp();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Entered just after a rising edge; ends one edge after release so the next call never re-drives psel
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rdata, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        check(what, r, exp);
        check("pslverr", e, expErr);
    endtask

    // One-cycle pulse on the wake input, or on the sleep input when wake is low
    task automatic pulse(input logic wake);
        if (wake) begin
            extIrqWake <= 1'b1;
        end else begin
            sleepExec <= 1'b1;
        end
        tick(1);
        extIrqWake <= 1'b0;
        sleepExec <= 1'b0;
    endtask

    task automatic do_reset(input logic wd);
        watchdogReset <= wd;
        rst <= 1'b1;
        tick(4);
        rst <= 1'b0;
        tick(4);
    endtask

    task automatic set_pins(input logic [1:0] p);
        mode_pin_hi <= p[1];
        mode_pin_lo <= p[0];
        tick(5);
    endtask

    // Standby with the given control word, then wake and count the halted edges
    task automatic standby_wake(input logic [31:0] cfg, input int states);
        int n;
        n = 0;
        wr(`SCM_SYSCTL_ADDR, cfg);
        pulse(1'b0);
        tick(20);
        check("standby cpu", cpuHalt, 1'b1);
        check("standby periph", periphHalt, 1'b1);
        check("standby init", periphInit, 1'b1);
        pulse(1'b1);
        while (periphHalt === 1'b1 && n < states + 100) begin
            @(posedge clk);
            n++;
        end
        check("settle span", n >= states && n <= states + 6, 1'b1);
        check("cpu resumed", cpuHalt, 1'b0);
        check("init released", periphInit, 1'b0);
    endtask

    task automatic nmi_watch(input logic lvl, input int exp);
        int n;
        n = 0;
        nmiPin <= lvl;
        repeat (10) begin
            @(posedge clk);
            if (nmiRequest === 1'b1) n++;
        end
        check("nmiRequest count", n, exp);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd("sysctl reset", `SCM_SYSCTL_ADDR, 32'h00000009, 1'b0);
        check("host reset", host_port_enable, 1'b0);
        check("ram reset", onchip_ram_enable, 1'b1);
        wr(`SCM_SYSCTL_ADDR, 32'hFFFFFFF7);
        rd("sysctl ones", `SCM_SYSCTL_ADDR, 32'h000000FF, 1'b0);
        check("host on", host_port_enable, 1'b1);
        wr(`SCM_SYSCTL_ADDR, 32'hFFFFFF00);
        rd("sysctl zeros", `SCM_SYSCTL_ADDR, 32'h00000008, 1'b0);
        check("host off", host_port_enable, 1'b0);
        check("ram off", onchip_ram_enable, 1'b0);
        rd("unmapped", 12'h008, 32'h00000000, 1'b1);
        wr(12'h008, 32'h000000FF);
        rd("after unmapped write", `SCM_SYSCTL_ADDR, 32'h00000008, 1'b0);
    endtask

    task automatic t_mode();
        for (int i = 1; i < 4; i++) begin
            set_pins(i[1:0]);
            rd("mode image", `SCM_MODECTL_ADDR, {24'h000000, `SCM_MODECTL_FIXED | i[7:0]}, 1'b0);
            check("opMode", opMode, i[1:0]);
            check("route", ramRouteOffchip, i < 3);
        end
        wr(`SCM_MODECTL_ADDR, 32'h0000001B);
        rd("mode write ignored", `SCM_MODECTL_ADDR, 32'h000000E7, 1'b0);
    endtask

    task automatic t_sleep();
        wr(`SCM_SYSCTL_ADDR, 32'h00000001);
        ce <= 1'b0;
        pulse(1'b0);
        tick(2);
        check("frozen sleep", cpuHalt, 1'b0);
        ce <= 1'b1;
        tick(1);
        pulse(1'b0);
        tick(2);
        check("sleep cpu", cpuHalt, 1'b1);
        check("sleep periph", periphHalt, 1'b0);
        pulse(1'b1);
        tick(3);
        check("sleep wake", cpuHalt, 1'b0);
    endtask

    // No code reaches the 8 ms floor at this bench clock; short codes keep the run short
    task automatic t_standby();
        set_pins(2'h1);
        standby_wake(32'h000000D0, 1024);
        rd("after wake", `SCM_SYSCTL_ADDR, 32'h000000D8, 1'b0);
        check("route kept", ramRouteOffchip, 1'b1);
        wr(`SCM_SYSCTL_ADDR, 32'h00000080);
        rd("restored code", `SCM_SYSCTL_ADDR, 32'h00000088, 1'b0);
        standby_wake(32'h00000080, 8192);
        rd("after long wake", `SCM_SYSCTL_ADDR, 32'h00000088, 1'b0);
    endtask

    task automatic t_nmi();
        nmi_watch(1'b0, 1);
        nmi_watch(1'b1, 0);
        wr(`SCM_SYSCTL_ADDR, 32'h00000084);
        nmi_watch(1'b0, 0);
        nmi_watch(1'b1, 1);
    endtask

    task automatic t_resets();
        do_reset(1'b1);
        rd("watchdog reset", `SCM_SYSCTL_ADDR, 32'h00000001, 1'b0);
        wr(`SCM_SYSCTL_ADDR, 32'h00000008);
        rd("flag not writable", `SCM_SYSCTL_ADDR, 32'h00000000, 1'b0);
        do_reset(1'b0);
        rd("external reset", `SCM_SYSCTL_ADDR, 32'h00000009, 1'b0);
    endtask

    initial begin
        do_reset(1'b0);
        t_regs();
        t_mode();
        t_sleep();
        t_standby();
        t_nmi();
        t_resets();
        wrapUp();
    end
endmodule
`default_nettype wire
